//--- core/iobc_channel.sv
`timescale 1ns/1ps
`include "iobc_defines.svh"

// Function
// - Single-cycle request alone means transfer out
// - Both requests together mean transfer in
// - Channel request alone: multi-cycle, add; with increment request: increment
// - Request only with chain enable; cut chain
// - On grant drive word-count or memory address
// - Respond only to own six-line code
// - Increment request bumps word at address
// - Controller drives fifteen address lines
// - Trap address driven during interrupt break
// - Word-count address for multi, increment, add
// - Absolute address for single-cycle transfers

module iobc_channel
	import iobc_pkg::*;
#(
	parameter logic [`IOBC_DS_W-1:0] DEV_CODE = `IOBC_DEV_CODE  // Arbitrary default code
) (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    reset_n,
	// User side
	input  wire logic                    opStart,
	input  wire iobc_op_t                opKind,
	input  wire logic [`IOBC_ADDR_W-1:0] wordCountAddr,
	input  wire logic [`IOBC_ADDR_W-1:0] memoryAddr,
	input  wire logic [`IOBC_ADDR_W-1:0] trapAddr,
	input  wire logic                    interruptBreak,
	output logic                         opBusy,
	output logic                         opDone,
	output logic                         deviceSelected,
	// Daisy chain and grant
	input  wire logic                    channelEnableChainIn,
	output logic                         channelEnableChainOut,
	input  wire logic                    channelGrant,
	// Requests, active low
	output logic                         channelRequest_n,
	output logic                         singleCycleRequest_n,
	output logic                         incrementMemoryRequest_n,
	// Device select lines
	input  wire logic [`IOBC_DS_W-1:0]   devSelect,
	// Address bus, open drain
	output logic [`IOBC_ADDR_W-1:0]      ioAddrOut_n,
	output logic                         ioAddrOe
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	iobc_state_t               state_ff;        // Sequencer state
	iobc_state_t               nxt_state;
	iobc_op_t                  kind_ff;         // Operation latched at start
	iobc_op_t                  nxt_kind;
	logic                      done_ff;         // One-cycle completion pulse
	logic                      nxt_done;
	logic                      selHit_ff;       // Registered select match
	logic                      nxt_selHit;
	logic [`IOBC_ADDR_W-1:0]   addr_ff;         // Address lines as driven, active low
	logic [`IOBC_ADDR_W-1:0]   nxt_addr;
	logic                      addrOe_ff;       // Address bus enable
	logic                      nxt_addrOe;
	logic                      posting;         // Request or grant in progress
	logic                      isSingle;        // Latched kind is single-cycle
	iobc_sel_if                selBus();        // Link to decoder

	// ----------------------------------------------------------------
	// Device select decode
	// ----------------------------------------------------------------
	assign selBus.lines = devSelect;

	iobc_dev_select #(
		.DEV_CODE (DEV_CODE)
	) u_dev_select (
		.sel (selBus.dec)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	assign posting  = (state_ff != IOBC_IDLE);
	assign isSingle = (kind_ff == IOBC_OP_SINGLE_IN) || (kind_ff == IOBC_OP_SINGLE_OUT);

	// Next state, kind and completion pulse
	always_comb begin
		nxt_state = state_ff;
		nxt_kind  = kind_ff;
		nxt_done  = 1'b0;
		case (state_ff)
			IOBC_IDLE: begin
				// A start without chain enable is simply not taken
				if (opStart && channelEnableChainIn) begin
					nxt_state = IOBC_REQ;
					nxt_kind  = opKind;
				end
			end
			IOBC_REQ: begin
				// Hold the request until the processor grants it
				if (channelGrant) begin
					nxt_state = IOBC_GRANT;
				end
			end
			IOBC_GRANT: begin
				// Grant withdrawn marks the end of the bus cycle
				if (!channelGrant) begin
					nxt_state = IOBC_IDLE;
					nxt_done  = 1'b1;
				end
			end
			default: begin
				nxt_state = IOBC_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_ff <= IOBC_IDLE;
			kind_ff  <= IOBC_OP_MULTI;
			done_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			kind_ff  <= nxt_kind;
			done_ff  <= nxt_done;
		end
	end

	// ----------------------------------------------------------------
	// Request encoding
	// ----------------------------------------------------------------
	// Requests stand only in the request state, so they clear on the clock after the grant
	always_comb begin
		channelRequest_n         = 1'b1;
		singleCycleRequest_n     = 1'b1;
		incrementMemoryRequest_n = 1'b1;
		if (state_ff == IOBC_REQ) begin
			case (kind_ff)
				IOBC_OP_SINGLE_OUT: begin
					singleCycleRequest_n = 1'b0;
				end
				IOBC_OP_SINGLE_IN: begin
					channelRequest_n     = 1'b0;
					singleCycleRequest_n = 1'b0;
				end
				IOBC_OP_INC: begin
					channelRequest_n         = 1'b0;
					incrementMemoryRequest_n = 1'b0;
				end
				default: begin
					channelRequest_n = 1'b0;
				end
			endcase
		end
	end

	// Chain cut the moment a request is posted, no clock delay
	assign channelEnableChainOut = channelEnableChainIn && !posting;

	// ----------------------------------------------------------------
	// Address bus and select match
	// ----------------------------------------------------------------
	// Trap address wins: a break and a grant should not overlap
	// Kept in bus sense so the pins come straight from flip-flops
	always_comb begin
		nxt_addr   = `IOBC_ADDR_IDLE;
		nxt_addrOe = 1'b0;
		nxt_selHit = selBus.hit;
		if (interruptBreak) begin
			nxt_addr   = ~trapAddr;
			nxt_addrOe = 1'b1;
		end else if (posting && channelGrant) begin
			nxt_addrOe = 1'b1;
			if (isSingle) begin
				nxt_addr = ~memoryAddr;
			end else begin
				nxt_addr = ~wordCountAddr;
			end
		end
	end

	// Address registers, one cycle behind grant or break
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			addr_ff   <= `IOBC_ADDR_IDLE;
			addrOe_ff <= 1'b0;
			selHit_ff <= 1'b0;
		end else begin
			addr_ff   <= nxt_addr;
			addrOe_ff <= nxt_addrOe;
			selHit_ff <= nxt_selHit;
		end
	end

	// Active-low lines; idle level whenever not enabled
	assign ioAddrOut_n    = addr_ff;
	assign ioAddrOe       = addrOe_ff;
	assign opBusy         = posting;
	assign opDone         = done_ff;
	assign deviceSelected = selHit_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_chain_cut: assert property (posting |-> !channelEnableChainOut)
		else $error("chain enable passed on while requesting");
	a_req_enable: assert property ($rose(posting) |-> $past(channelEnableChainIn))
		else $error("request posted without chain enable");
	a_single_out: assert property (state_ff == IOBC_REQ && kind_ff == IOBC_OP_SINGLE_OUT
		|-> !singleCycleRequest_n && channelRequest_n)
		else $error("single-cycle out encoded wrongly");
	a_single_in: assert property (state_ff == IOBC_REQ && kind_ff == IOBC_OP_SINGLE_IN
		|-> !singleCycleRequest_n && !channelRequest_n)
		else $error("single-cycle in encoded wrongly");
	a_multi_enc: assert property (state_ff == IOBC_REQ && !isSingle
		|-> !channelRequest_n && singleCycleRequest_n)
		else $error("multi-cycle request encoded wrongly");
	a_inc_req: assert property (!incrementMemoryRequest_n
		|-> kind_ff == IOBC_OP_INC && !channelRequest_n)
		else $error("increment request without its operation");
	a_dev_hit: assert property (deviceSelected == $past(devSelect == DEV_CODE))
		else $error("device select match wrong");
	a_trap_addr: assert property (interruptBreak |=> ioAddrOe && ioAddrOut_n == ~$past(trapAddr))
		else $error("trap address not driven");
	a_wc_addr: assert property (!interruptBreak && posting && channelGrant && !isSingle
		|=> ioAddrOe && ioAddrOut_n == ~$past(wordCountAddr))
		else $error("word-count address not driven");
	a_abs_addr: assert property (!interruptBreak && posting && channelGrant && isSingle
		|=> ioAddrOe && ioAddrOut_n == ~$past(memoryAddr))
		else $error("memory address not driven");
	a_addr_release: assert property (!interruptBreak && !(posting && channelGrant)
		|=> !ioAddrOe && ioAddrOut_n == `IOBC_ADDR_IDLE)
		else $error("address bus not released");

	c_single_out: cover property (state_ff == IOBC_REQ && kind_ff == IOBC_OP_SINGLE_OUT ##1 channelGrant);
	c_single_in: cover property (state_ff == IOBC_REQ && kind_ff == IOBC_OP_SINGLE_IN ##1 channelGrant);
	c_increment: cover property (!incrementMemoryRequest_n ##[1:20] opDone);
	c_trap: cover property (interruptBreak ##1 ioAddrOe);

endmodule : iobc_channel

//--- core/iobc_defines.svh
`ifndef IOBC_DEFINES_SVH
`define IOBC_DEFINES_SVH

// ----------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------
`define IOBC_ADDR_W     15
`define IOBC_DS_W       6

// ----------------------------------------------------------------
// Address bus levels
// ----------------------------------------------------------------
`define IOBC_ADDR_ZERO  15'h0000
`define IOBC_ADDR_IDLE  15'h7FFF

// ----------------------------------------------------------------
// Default device code (arbitrary value)
// ----------------------------------------------------------------
`define IOBC_DEV_CODE   6'h2A

`endif

//--- core/iobc_pkg.sv
`include "iobc_defines.svh"

package iobc_pkg;

	// ----------------------------------------------------------------
	// Operation kinds posted by the controller
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		IOBC_OP_MULTI,
		IOBC_OP_SINGLE_IN,
		IOBC_OP_SINGLE_OUT,
		IOBC_OP_INC,
		IOBC_OP_ADD
	} iobc_op_t;

	// ----------------------------------------------------------------
	// Channel sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IOBC_IDLE,
		IOBC_REQ,
		IOBC_GRANT
	} iobc_state_t;

endpackage : iobc_pkg

//--- core/iobc_sel_if.sv
`timescale 1ns/1ps
`include "iobc_defines.svh"

// Device select lines and the decoded match
interface iobc_sel_if;
	logic [`IOBC_DS_W-1:0] lines;   // Six select lines as seen on the bus
	logic                  hit;     // Lines carry this controller's code

	modport ctrl (output lines, input hit);
	modport dec  (input lines, output hit);
endinterface : iobc_sel_if

//--- core/iobc_dev_select.sv
`timescale 1ns/1ps
`include "iobc_defines.svh"

// ----------------------------------------------------------------
// Device select decoder
// ----------------------------------------------------------------
module iobc_dev_select
	import iobc_pkg::*;
#(
	parameter logic [`IOBC_DS_W-1:0] DEV_CODE = `IOBC_DEV_CODE  // Arbitrary default code
) (
	// Select lines in, match out
	iobc_sel_if.dec sel
);

	// Line 0 holds instruction bit 6, later lines the following bits
	// All six lines compared at once, any other code ignored
	assign sel.hit = (sel.lines == DEV_CODE);

endmodule : iobc_dev_select

//--- testbench/iobc_proc_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Processor side of the channel: grants and decodes requests
// ----------------------------------------------------------------
module iobc_proc_model (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// Requests from the controller, low active
	input  wire logic       chReq_n,
	input  wire logic       scReq_n,
	input  wire logic       incReq_n,
	input  wire logic [3:0] lag,      // Cycles before grant
	// Grant and what it was granted for
	output logic            grant,
	output logic [1:0]      kindSeen, // {channel, single}
	output logic            incSeen
);
	logic [3:0] waitCnt;              // Cycles the request has waited

	// Grant after the lag; drop it only once the requests are withdrawn
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			grant   <= 1'b0;
			waitCnt <= 4'h0;
		end else if (grant) begin
			grant   <= !(chReq_n && scReq_n);  // Increment done in this one grant
			waitCnt <= 4'h0;
		end else if (!chReq_n || !scReq_n) begin
			waitCnt <= waitCnt + 4'h1;
			if (waitCnt >= lag) begin
				grant    <= 1'b1;
				kindSeen <= {~chReq_n, ~scReq_n};
				incSeen  <= ~incReq_n;
			end
		end
	end
endmodule : iobc_proc_model

//--- testbench/io_bus_channel_request_addressing_bench.sv
`timescale 1ns/1ps
`include "iobc_defines.svh"

module io_bus_channel_request_addressing_bench
	import iobc_pkg::*;
;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic              sys_clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              opStart = 1'b0;
	iobc_op_t          opKind  = IOBC_OP_MULTI;
	logic [14:0]       wcAddr  = 15'h1234;
	logic [14:0]       memAddr = 15'h5A5A;
	logic [14:0]       trap    = 15'h0C30;
	logic              brk     = 1'b0;
	logic              chainIn = 1'b1;
	logic [5:0]        devSel  = 6'h00;
	logic [3:0]        lag     = 4'h0;
	logic              busy, done, hit, chainOut, grant, incSeen, oe;
	logic              chReq_n, scReq_n, incReq_n;
	logic [1:0]        kindSeen;
	logic [14:0]       addr_n;
	int                errorCnt = 0;  // Mismatches seen
	int                cmpCount = 0;  // Comparisons made

	always #2 sys_clk = ~sys_clk;     // 250 MHz

	iobc_channel dut (.sys_clk(sys_clk), .reset_n(reset_n), .opStart(opStart), .opKind(opKind),
		.wordCountAddr(wcAddr), .memoryAddr(memAddr), .trapAddr(trap), .interruptBreak(brk),
		.opBusy(busy), .opDone(done), .deviceSelected(hit), .channelEnableChainIn(chainIn),
		.channelEnableChainOut(chainOut), .channelGrant(grant), .channelRequest_n(chReq_n),
		.singleCycleRequest_n(scReq_n), .incrementMemoryRequest_n(incReq_n), .devSelect(devSel),
		.ioAddrOut_n(addr_n), .ioAddrOe(oe));

	iobc_proc_model proc (.sys_clk(sys_clk), .reset_n(reset_n), .chReq_n(chReq_n), .scReq_n(scReq_n),
		.incReq_n(incReq_n), .lag(lag), .grant(grant), .kindSeen(kindSeen), .incSeen(incSeen));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errorCnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Step n clocks and let their updates land
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic give_verdict;
		if (errorCnt == 0 && cmpCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// One channel operation of a given kind, granted after a lag
	task automatic run_op(input iobc_op_t k, input logic [3:0] l);
		logic [14:0] exp;
		int          n;
		exp = (k == IOBC_OP_SINGLE_IN || k == IOBC_OP_SINGLE_OUT) ? memAddr : wcAddr;
		n   = 0;
		@(posedge sys_clk) begin
			opStart <= 1'b1;
			opKind  <= k;
			lag     <= l;
		end
		@(posedge sys_clk) opStart <= 1'b0;
		#1;
		chk({chainOut, busy}, 16'h0001);
		while (oe !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		chk({1'b0, addr_n}, {1'b0, ~exp});
		chk(kindSeen, (k == IOBC_OP_SINGLE_IN) ? 3 : (k == IOBC_OP_SINGLE_OUT) ? 1 : 2);
		chk(incSeen, k == IOBC_OP_INC);
		while (done !== 1'b1 && n < 80) begin
			tick(1);
			n++;
		end
		chk(done, 1'b1);
		chk({oe, addr_n}, 16'h7FFF);
	endtask : run_op

	// Start while the chain enable is low: nothing may be posted
	task automatic refused_op;
		@(posedge sys_clk) begin
			chainIn <= 1'b0;
			opStart <= 1'b1;
		end
		@(posedge sys_clk) opStart <= 1'b0;
		tick(3);
		chk({chReq_n, scReq_n, incReq_n, busy, chainOut}, 16'h001C);
		@(posedge sys_clk) chainIn <= 1'b1;
	endtask : refused_op

	// Interrupt break puts the trap address out, then releases
	task automatic trap_break;
		@(posedge sys_clk) brk <= 1'b1;
		tick(2);
		chk({oe, addr_n}, {1'b1, ~trap});
		@(posedge sys_clk) brk <= 1'b0;
		tick(2);
		chk({oe, addr_n}, 16'h7FFF);
	endtask : trap_break

	// Own code matches; each single-bit neighbour is ignored
	task automatic select_codes;
		for (int i = 0; i < 7; i++) begin
			@(posedge sys_clk) devSel <= (i == 6) ? `IOBC_DEV_CODE : `IOBC_DEV_CODE ^ (6'h01 << i);
			tick(1);
			chk(hit, i == 6);
		end
	endtask : select_codes

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		tick(5);
		chk({chReq_n, scReq_n, incReq_n, oe, chainOut}, 16'h001D);
		@(posedge sys_clk) reset_n <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			run_op(iobc_op_t'(k), 4'(k * 3));
		end
		run_op(IOBC_OP_INC, 4'h0);
		refused_op();
		trap_break();
		select_codes();
		give_verdict();
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		errorCnt++;
		give_verdict();
	end
endmodule : io_bus_channel_request_addressing_bench
